// >>> src/adc_pair_ctrl.sv
// Controller end: Wishbone registers drive select write, wait and result read
//
// Our own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ns
module adc_pair_ctrl #(
  parameter int CONV_WAIT = adc_pair_pkg::CONV_WAIT_CYC
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Backplane
  backplane_if.ctrl        bp
);

  // ****************************************
  // Registers
  // ****************************************
  adc_pair_pkg::seq_state_e                 state;
  logic [adc_pair_pkg::CODE_W-1:0]          code;
  logic [adc_pair_pkg::WORD_W-1:0]          word;
  logic [adc_pair_pkg::ADDR_W-1:0]          base;
  logic                                     done;
  logic [adc_pair_pkg::WAIT_W-1:0]          wait_cnt;

  // ****************************************
  // Wishbone decode
  // ****************************************
  wire        req       = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Writes land at the edge where the master sees ack, with the request still held
  wire        wr_req    = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
  wire        cmd_wr    = wr_req && (wb_adr_i == adc_pair_pkg::REG_COMMAND) && (state == adc_pair_pkg::ST_IDLE);
  wire        base_wr   = wr_req && (wb_adr_i == adc_pair_pkg::REG_BASE);
  wire        bipolar   = code[adc_pair_pkg::BIPOLAR_BIT];
  wire [31:0] low_val   = adc_pair_pkg::widen(word[adc_pair_pkg::LOW_LSB +: adc_pair_pkg::RESULT_W], bipolar);
  wire [31:0] high_val  = adc_pair_pkg::widen(word[adc_pair_pkg::HIGH_LSB +: adc_pair_pkg::RESULT_W], bipolar);
  wire        busy      = (state != adc_pair_pkg::ST_IDLE);
  wire [31:0] rd_mux    = (wb_adr_i == adc_pair_pkg::REG_COMMAND) ? {28'h000_0000, code} :
                          (wb_adr_i == adc_pair_pkg::REG_STATUS)  ? {30'h0000_0000, done, busy} :
                          (wb_adr_i == adc_pair_pkg::REG_WORD)    ? {8'h00, word} :
                          (wb_adr_i == adc_pair_pkg::REG_LOW)     ? low_val :
                          (wb_adr_i == adc_pair_pkg::REG_HIGH)    ? high_val :
                          (wb_adr_i == adc_pair_pkg::REG_BASE)    ? {24'h00_0000, base} : 32'h0000_0000;

  // Registered ack and read data; unmapped reads give zero
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= req ? rd_mux : wb_dat_o;
    end
  end

  // Board base address setting
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      base <= adc_pair_pkg::BASE_RESET;
    end else if (base_wr) begin
      base <= wb_dat_i[adc_pair_pkg::ADDR_W-1:0];
    end
  end

  // ****************************************
  // Sequencer: write code, wait, read word
  // ****************************************
  wire wait_over = (wait_cnt == adc_pair_pkg::WAIT_W'(CONV_WAIT - 1));

  assign bp.addr  = base;
  assign bp.wr    = (state == adc_pair_pkg::ST_WRITE);
  assign bp.rd    = (state == adc_pair_pkg::ST_READ);
  assign bp.wdata = {20'h0_0000, code};

  // Done is cleared by a new command and set when the read completes
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state    <= adc_pair_pkg::ST_IDLE;
      code     <= adc_pair_pkg::CODE_RESET;
      word     <= adc_pair_pkg::RESULT_RESET;
      done     <= 1'b0;
      wait_cnt <= '0;
    end else begin
      unique case (state)
        adc_pair_pkg::ST_IDLE: begin
          if (cmd_wr) begin
            code  <= wb_dat_i[adc_pair_pkg::CODE_W-1:0];
            done  <= 1'b0;
            state <= adc_pair_pkg::ST_WRITE;
          end
        end
        adc_pair_pkg::ST_WRITE: begin
          wait_cnt <= '0;
          if (bp.ack) begin
            state <= adc_pair_pkg::ST_WAIT;
          end
        end
        adc_pair_pkg::ST_WAIT: begin
          wait_cnt <= wait_cnt + 1'b1;
          if (wait_over) begin
            state <= adc_pair_pkg::ST_READ;
          end
        end
        adc_pair_pkg::ST_READ: begin
          if (bp.ack) begin
            word  <= bp.rdata;
            done  <= 1'b1;
            state <= adc_pair_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

endmodule : adc_pair_ctrl

// >>> src/adc_pair_pkg.sv
// Shared constants, types and helpers for the channel-pair conversion port
package adc_pair_pkg;

  // ****************************************
  // Word and field layout
  // ****************************************
  localparam int WORD_W        = 24;
  localparam int RESULT_W      = 12;
  localparam int CODE_W        = 4;
  localparam int ADDR_W        = 8;
  localparam int LOW_LSB       = 0;
  localparam int HIGH_LSB      = 12;
  localparam int BIPOLAR_BIT   = 3;
  localparam int PAIR_COUNT    = 8;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [WORD_W-1:0] RESULT_RESET = 24'h00_0000;
  localparam logic [CODE_W-1:0] CODE_RESET   = 4'h0;
  localparam logic [ADDR_W-1:0] BASE_RESET   = 8'h00;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS  = 10;
  localparam int CONV_WAIT_NS   = 5000;
  localparam int CONV_WAIT_CYC  = (CONV_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAIT_W         = 16;

  // ****************************************
  // Controller register map (byte offsets)
  // ****************************************
  localparam logic [7:0] REG_COMMAND = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_WORD    = 8'h08;
  localparam logic [7:0] REG_LOW     = 8'h0C;
  localparam logic [7:0] REG_HIGH    = 8'h10;
  localparam logic [7:0] REG_BASE    = 8'h14;
  localparam int         STAT_BUSY   = 0;
  localparam int         STAT_DONE   = 1;

  // Controller sequencer states, Gray along the path
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WRITE = 2'b01,
    ST_WAIT  = 2'b11,
    ST_READ  = 2'b10
  } seq_state_e;

  // Lower channel number 1..8 chosen by a select code
  function automatic logic [4:0] lower_channel(input logic [CODE_W-1:0] code);
    lower_channel = {2'b00, code[2:0]} + 5'h01;
  endfunction : lower_channel

  // Widen a 12-bit result, signed when bipolar
  function automatic logic [31:0] widen(input logic [RESULT_W-1:0] v, input logic bipolar);
    widen = bipolar ? {{20{v[RESULT_W-1]}}, v} : {20'h0_0000, v};
  endfunction : widen

endpackage : adc_pair_pkg

// >>> src/backplane_if.sv
// Backplane word bus between the controller and the conversion board
`timescale 1ns/1ns
interface backplane_if;
  logic [adc_pair_pkg::ADDR_W-1:0] addr;
  logic                            wr;
  logic                            rd;
  logic [adc_pair_pkg::WORD_W-1:0] wdata;
  logic [adc_pair_pkg::WORD_W-1:0] rdata;
  logic                            ack;

  modport board (input addr, input wr, input rd, input wdata, output rdata, output ack);
  modport ctrl  (output addr, output wr, output rd, output wdata, input rdata, input ack);
endinterface : backplane_if

// >>> src/adc_pair_board.sv
// Conversion board end: one select/result word on the backplane
`timescale 1ns/1ns

// Summary of operation
// - Select-word write starts a conversion
// - Written code picks pair and polarity
// - Codes 0-7 unipolar, 8-15 bipolar pairs
// - Lower channel result in bits 0-11
// - Upper channel result in bits 12-23
// - Host reads bipolar results as signed
// - Host reads unipolar results as unsigned
// - Host waits before reading results
// - Upper field valid only with second bank
// - One 24-bit word for select and results
// - Base address set by board chip select
// - Polarity shared by both pair channels
module adc_pair_board (
  // Clock and reset
  input  wire logic                                mclk,
  input  wire logic                                rstn,
  // Backplane
  backplane_if.board                               bp,
  // Board straps
  input  wire logic [adc_pair_pkg::ADDR_W-1:0]     board_base_chip_select,
  input  wire logic                                bank2_fitted,
  // Converter side
  output logic                                     conv_start,
  output logic [4:0]                               conv_lower_channel,
  output logic [4:0]                               conv_upper_channel,
  output logic                                     conv_bipolar,
  input  wire logic                                conv_done,
  input  wire logic [adc_pair_pkg::RESULT_W-1:0]   conv_lower_data,
  input  wire logic [adc_pair_pkg::RESULT_W-1:0]   conv_upper_data
);

  // ****************************************
  // Base address strap synchroniser
  // ****************************************
  logic [adc_pair_pkg::ADDR_W-1:0] base_s1;
  logic [adc_pair_pkg::ADDR_W-1:0] base_s2;
  logic [adc_pair_pkg::ADDR_W-1:0] base_s3;
  logic [adc_pair_pkg::ADDR_W-1:0] base;

  // Three stages; base moves only once stages two and three agree
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      base_s1 <= adc_pair_pkg::BASE_RESET;
      base_s2 <= adc_pair_pkg::BASE_RESET;
      base_s3 <= adc_pair_pkg::BASE_RESET;
      base    <= adc_pair_pkg::BASE_RESET;
    end else begin
      base_s1 <= board_base_chip_select;
      base_s2 <= base_s1;
      base_s3 <= base_s2;
      if (base_s2 == base_s3) begin
        base <= base_s3;
      end
    end
  end

  // ****************************************
  // Bus decode
  // ****************************************
  logic [adc_pair_pkg::CODE_W-1:0] code;
  logic [adc_pair_pkg::WORD_W-1:0] result;
  logic                            ack;
  wire                             hit      = (bp.addr == base);
  wire                             wr_take  = hit && bp.wr && !ack;
  wire                             rd_take  = hit && bp.rd && !bp.wr && !ack;
  wire  [adc_pair_pkg::CODE_W-1:0] wr_code  = bp.wdata[adc_pair_pkg::CODE_W-1:0];
  wire  [4:0]                      low_ch   = adc_pair_pkg::lower_channel(wr_code);

  assign bp.ack = ack;

  // One-cycle registered answer; ack drops the cycle after it is given
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ack      <= 1'b0;
      bp.rdata <= adc_pair_pkg::RESULT_RESET;
    end else begin
      ack <= wr_take || rd_take;
      if (rd_take) begin
        bp.rdata <= result;
      end
    end
  end

  // ****************************************
  // Conversion request
  // ****************************************
  // Latch the code and fire one start pulse per select write
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      code               <= adc_pair_pkg::CODE_RESET;
      conv_start         <= 1'b0;
      conv_lower_channel <= 5'h01;
      conv_upper_channel <= 5'h09;
      conv_bipolar       <= 1'b0;
    end else begin
      conv_start <= wr_take;
      if (wr_take) begin
        code               <= wr_code;
        conv_lower_channel <= low_ch;
        conv_upper_channel <= low_ch + 5'h08;
        conv_bipolar       <= wr_code[adc_pair_pkg::BIPOLAR_BIT];
      end
    end
  end

  // ****************************************
  // Result word
  // ****************************************
  wire [adc_pair_pkg::RESULT_W-1:0] upper_field = bank2_fitted ? conv_upper_data : 12'h000;

  // Results change only on converter completion and stay until the next one
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      result <= adc_pair_pkg::RESULT_RESET;
    end else if (conv_done) begin
      result[adc_pair_pkg::LOW_LSB +: adc_pair_pkg::RESULT_W]  <= conv_lower_data;
      result[adc_pair_pkg::HIGH_LSB +: adc_pair_pkg::RESULT_W] <= upper_field;
    end
  end

endmodule : adc_pair_board

// >>> verif/adc_pair_monitor.sv
// Checker of the backplane word bus between controller and board
`timescale 1ns/1ns
module adc_pair_monitor (
  // Clock and reset
  input wire logic                            mclk,
  input wire logic                            rstn,
  // Backplane
  input wire logic [adc_pair_pkg::ADDR_W-1:0] addr,
  input wire logic                            wr,
  input wire logic                            rd,
  input wire logic [adc_pair_pkg::WORD_W-1:0] wdata,
  input wire logic [adc_pair_pkg::WORD_W-1:0] rdata,
  input wire logic                            ack
);
  // ****************************************
  // Bus properties
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  // Write answered, then a quiet gap before the read
  sequence s_wr_ack;
    wr && ack;
  endsequence
  sequence s_rd_quiet;
    !rd [*2];
  endsequence

  a_ack_from_req: assert property (ack |-> $past(wr || rd)) else $error("ack without request");
  a_ack_one_pulse: assert property (ack |=> !ack) else $error("ack longer than one cycle");
  a_wr_held: assert property (wr && !ack |=> wr && $stable(wdata) && $stable(addr)) else $error("write dropped");
  a_rd_held: assert property (rd && !ack |=> rd && $stable(addr)) else $error("read dropped");
  a_code_width: assert property (wr |-> wdata[23:4] == 20'h0_0000) else $error("select word not zero filled");
  a_single_dir: assert property (!(wr && rd)) else $error("read and write together");
  a_result_hold: assert property ($changed(rdata) |-> ack && $past(rd)) else $error("result moved");
  a_read_gap: assert property (s_wr_ack |=> s_rd_quiet) else $error("read too soon after select");
  a_wr_answered: assert property ($rose(wr) |-> ##[1:8] ack) else $error("write not answered");
  a_rd_answered: assert property ($rose(rd) |-> ##[1:8] ack) else $error("read not answered");
endmodule : adc_pair_monitor

// >>> verif/adc_pair_convert_port_tb.sv
// Testbench joining controller and board over the backplane
`timescale 1ns/1ns
module adc_pair_convert_port_tb;
  logic        mclk, rstn, wb_cyc, wb_stb, wb_we, bank2, conv_start, conv_bipolar;
  logic [7:0]  wb_adr, strap;
  logic [31:0] wb_dat, wb_dat_o;
  logic        wb_ack_o;
  logic [4:0]  conv_lower_channel, conv_upper_channel;
  logic        conv_done = 1'b0;
  logic [11:0] conv_lower_data = 12'h000;
  logic [11:0] conv_upper_data = 12'h000;
  logic [3:0]  code = 4'h0;
  int          errors = 0;
  int          comparisons = 0;

  backplane_if bp ();
  adc_pair_ctrl #(.CONV_WAIT(4)) adc_pair_ctrl_i (.mclk(mclk), .rstn(rstn), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .bp(bp));
  adc_pair_board adc_pair_board_i (.mclk(mclk), .rstn(rstn), .bp(bp), .board_base_chip_select(strap),
    .bank2_fitted(bank2), .conv_start(conv_start), .conv_lower_channel(conv_lower_channel),
    .conv_upper_channel(conv_upper_channel), .conv_bipolar(conv_bipolar), .conv_done(conv_done),
    .conv_lower_data(conv_lower_data), .conv_upper_data(conv_upper_data));
  adc_pair_monitor adc_pair_monitor_i (.mclk(mclk), .rstn(rstn), .addr(bp.addr), .wr(bp.wr), .rd(bp.rd),
    .wdata(bp.wdata), .rdata(bp.rdata), .ack(bp.ack));

  // ****************************************
  // Clock, converter model and tasks
  // ****************************************
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Converter answers one cycle after start
  always @(posedge mclk) begin
    conv_done <= conv_start;
    if (conv_start) begin
      chk(32'({conv_bipolar, conv_upper_channel, conv_lower_channel}),
          32'({code[3], 5'(code[2:0]) + 5'h09, 5'(code[2:0]) + 5'h01}));
      conv_lower_data <= {conv_bipolar ? 4'hF : 4'h1, 3'h0, conv_lower_channel};
      conv_upper_data <= {conv_bipolar ? 4'hE : 4'h2, 3'h0, conv_upper_channel};
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task test_done;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  // Classic Wishbone single cycle, held until ack
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat <= dat;
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    if (wb_ack_o !== 1'b1) begin
      chk(32'h0000_0000, 32'h0000_0001);
      test_done();
    end
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge mclk);
  endtask : wb

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [31:0] q;
    logic [11:0] lo, hi;
    int n;
    rstn = 1'b0;
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} = '0;
    strap = 8'h35;
    bank2 = 1'b1;
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    repeat (6) @(posedge mclk);
    wb(1'b1, adc_pair_pkg::REG_BASE, 32'h0000_0035, q);
    wb(1'b0, 8'h18, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    for (int b = 1; b >= 0; b--) begin
      for (int c = 0; c < 16; c++) begin
        bank2 <= b[0];
        code = 4'(c);
        lo = {code[3] ? 4'hF : 4'h1, 3'h0, 5'(code[2:0]) + 5'h01};
        hi = b[0] ? {code[3] ? 4'hE : 4'h2, 3'h0, 5'(code[2:0]) + 5'h09} : 12'h000;
        wb(1'b1, adc_pair_pkg::REG_COMMAND, 32'(code), q);
        n = 0;
        q = 32'h0000_0000;
        while (q[1] !== 1'b1 && n < 30) begin
          wb(1'b0, adc_pair_pkg::REG_STATUS, 32'h0000_0000, q);
          n++;
        end
        chk(q, 32'h0000_0002);
        if (q[1] !== 1'b1) test_done();
        wb(1'b0, adc_pair_pkg::REG_WORD, 32'h0000_0000, q);
        chk(q, 32'({hi, lo}));
        wb(1'b0, adc_pair_pkg::REG_LOW, 32'h0000_0000, q);
        chk(q, {code[3] ? 20'hF_FFFF : 20'h0_0000, lo});
        wb(1'b0, adc_pair_pkg::REG_HIGH, 32'h0000_0000, q);
        chk(q, {(code[3] && hi[11]) ? 20'hF_FFFF : 20'h0_0000, hi});
        wb(1'b0, adc_pair_pkg::REG_WORD, 32'h0000_0000, q);
        chk(q, 32'({hi, lo}));
        $display("test code %0d bank %0d ended", c, b);
      end
    end
    test_done();
  end
endmodule : adc_pair_convert_port_tb
